// >>> src/resl_map.vh
// constants for the radio event and status logic
`ifndef RESL_MAP_VH
`define RESL_MAP_VH
// -----------------------------------------------------------
// command words
// -----------------------------------------------------------
`define RESL_CMD_BITS 16
`define RESL_DIV_CMD_HI 8'hC0
`define RESL_TXW_CMD_HI 8'hB8
`define RESL_DIV_RESET 16'hC000
`define RESL_DIV_SEL_HI 7
`define RESL_DIV_SEL_LO 5
`define RESL_DIV_ZERO_BIT 4
`define RESL_BAT_HI 3
`define RESL_BAT_LO 0
`define RESL_TX_PREAMBLE 8'hAA
// -----------------------------------------------------------
// status word positions
// -----------------------------------------------------------
`define RESL_ST_TXRDY_FILL 15
`define RESL_ST_POR 14
`define RESL_ST_UNDER_OVF 13
`define RESL_ST_WAKE 12
`define RESL_ST_EXT 11
`define RESL_ST_LOWBAT 10
`define RESL_ST_FIFO_EMPTY 9
// -----------------------------------------------------------
// low supply threshold in tenths of a volt: 2.2 V + code * 0.1 V
// -----------------------------------------------------------
`define RESL_BAT_BASE_DV 6'd22
`define RESL_BAT_STEP_DV 6'd1
// -----------------------------------------------------------
// timing: system clock and mcu clock choices in kHz
// -----------------------------------------------------------
`define RESL_SYS_KHZ 50000
`define RESL_MCU_KHZ_0 1000
`define RESL_MCU_KHZ_1 1250
`define RESL_MCU_KHZ_2 1660
`define RESL_MCU_KHZ_3 2000
`define RESL_MCU_KHZ_4 2500
`define RESL_MCU_KHZ_5 3330
`define RESL_MCU_KHZ_6 5000
`define RESL_MCU_KHZ_7 10000
// mcu clock period in system clocks, 1.66 and 3.33 MHz rounded
`define RESL_MCU_DIV_0 6'd50
`define RESL_MCU_DIV_1 6'd40
`define RESL_MCU_DIV_2 6'd30
`define RESL_MCU_DIV_3 6'd25
`define RESL_MCU_DIV_4 6'd20
`define RESL_MCU_DIV_5 6'd15
`define RESL_MCU_DIV_6 6'd10
`define RESL_MCU_DIV_7 6'd5
`define RESL_RX_FIFO_BITS 5'd16
`endif

// >>> src/resl_event_status.v
// radio event collection, status word, clock divider and transmit holding logic
`timescale 1ns/1ps
// Notes on behaviour
// - mcu clock output divided down; select 000..111 gives 1 to 10 MHz
// - divider command: upper byte C0, bits 7-5 select, bit 4 zero, 3-0 threshold
// - low supply threshold is 2.2 V plus code times 0.1 V
// - status bits 15 to 10 report the event sources, bit 9 reports the fifo empty
// - status bits 8 to 0 report radio quality and frequency offset
// - frequency offset field is reported as two's complement
// - any enabled active event pulls request low and sets its status bit
// - transmit holding empty event while enabled, until written or switched off
// - receive fill event when fifo bit count reaches the level
// - fill event holds until level bits read, receiver or fifo off
// - power-up event on reset or software reset command
// - status read clears power-up and wake timer events
// - underrun set with holding empty, holds until transmitter and latch off
// - overflow past 16 bits; read clears bit, request holds until fifo emptied
// - wake timer event on elapsed interval while enabled
// - external event follows the inverted external pin when selected
// - low supply event latches request; status bit holds while supply low
// - any event starts oscillator and clock output, blocks sleep
// - clock output disabled and radio off: oscillator follows its enable only
// - transmit bytes go into two 8-bit registers, sent once transmitter on
// - registers start at AA; serial output high when ready for next byte

// -----------------------------------------------------------
// byte queue in front of the transmit holding register
// -----------------------------------------------------------
module resl_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clk,
	input wire rst,
	input wire inValid,
	output wire inReady,
	input wire [WIDTH-1:0] inData,
	output wire outValid,
	input wire outReady,
	output wire [WIDTH-1:0] outData
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wrPtr_r;
	reg [AW-1:0] rdPtr_r;
	reg [AW:0] count_r;
	wire push;
	wire pop;

	assign inReady = (count_r != DEPTH[AW:0]);
	assign outValid = (count_r != {(AW+1){1'b0}});
	assign outData = mem[rdPtr_r];
	assign push = inValid & inReady;
	assign pop = outValid & outReady;

	always @(posedge clk) begin
		if (push) begin
			mem[wrPtr_r] <= inData;
		end
		if (rst) begin
			wrPtr_r <= {AW{1'b0}};
			rdPtr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wrPtr_r <= (wrPtr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_r + 1'b1;
			end
			if (pop) begin
				rdPtr_r <= (rdPtr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_r + 1'b1;
			end
			if (push & ~pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop & ~push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule // resl_fifo

// -----------------------------------------------------------
// top: event and status logic
// -----------------------------------------------------------
module resl_event_status #(
	parameter FIFO_DEPTH = 8
) (
	input wire clk,
	input wire rst,
	input wire spiSck,
	input wire spiSdi,
	input wire spiSel_n,
	output reg sdo_r,
	output reg interrupt_request_n_r,
	output reg mcuClkOut_r,
	output reg oscRun_r,
	output reg txSerial_r,
	output reg txQueueReady_r,
	output reg [5:0] lowSupplyThresh_r,
	input wire tx_register_enable,
	input wire transmitter_on,
	input wire rx_power_on,
	input wire rx_queue_enable,
	input wire wake_timer_enable,
	input wire battery_monitor_enable,
	input wire osc_enable,
	input wire clock_output_disable,
	input wire extPinSelect,
	input wire [3:0] fifo_level_threshold,
	input wire txBitTick,
	input wire rxBitStrobe,
	input wire rxBitTaken,
	input wire wakeIntervalDone,
	input wire softResetCmd,
	input wire supplyReset,
	input wire [5:0] supplyDecivolts,
	input wire outside_event_pin_n,
	input wire antennaStrong,
	input wire signalStrong,
	input wire data_quality_flag,
	input wire clockLocked,
	input wire afcToggle,
	input wire [3:0] freq_offset_field
);
`include "resl_map.vh"
	// -----------------------------------------------------------
	// pin synchronisers
	// -----------------------------------------------------------
	reg [1:0] sckSync_r;
	reg [1:0] sdiSync_r;
	reg [1:0] selSync_r;
	reg [1:0] extSync_r;
	reg sckLast_r;
	reg selLast_r;
	always @(posedge clk) begin
		sckSync_r <= {sckSync_r[0], spiSck};
		sdiSync_r <= {sdiSync_r[0], spiSdi};
		selSync_r <= {selSync_r[0], spiSel_n};
		extSync_r <= {extSync_r[0], outside_event_pin_n};
		sckLast_r <= sckSync_r[1];
		selLast_r <= selSync_r[1];
	end
	wire sckRise = sckSync_r[1] & ~sckLast_r;
	wire sckFall = ~sckSync_r[1] & sckLast_r;
	wire selStart = ~selSync_r[1] & selLast_r;
	wire selEnd = selSync_r[1] & ~selLast_r;
	wire selected = ~selSync_r[1];

	// -----------------------------------------------------------
	// serial command link
	// -----------------------------------------------------------
	reg [15:0] cmdShift_r;
	reg [4:0] bitCnt_r;
	reg [15:0] statusSnap_r;
	reg statusRead_r;
	reg [15:0] clkDivBat_r;
	wire [15:0] statusWord;
	wire frameDone = selEnd & (bitCnt_r == 5'd16);
	wire divCmd = frameDone & (cmdShift_r[15:8] == `RESL_DIV_CMD_HI)
		& ~cmdShift_r[`RESL_DIV_ZERO_BIT];
	wire txWrCmd = frameDone & (cmdShift_r[15:8] == `RESL_TXW_CMD_HI);
	wire readDone = selEnd & statusRead_r;
	always @(posedge clk) begin
		if (rst) begin
			cmdShift_r <= 16'h0000;
			bitCnt_r <= 5'd0;
			statusSnap_r <= 16'h0000;
			statusRead_r <= 1'b0;
			clkDivBat_r <= `RESL_DIV_RESET;
		end else begin
			if (selStart) begin
				bitCnt_r <= 5'd0;
				statusRead_r <= 1'b0;
				statusSnap_r <= statusWord;
			end else if (selected & sckRise) begin
				cmdShift_r <= {cmdShift_r[14:0], sdiSync_r[1]};
				if (bitCnt_r != 5'd16) begin
					bitCnt_r <= bitCnt_r + 5'd1;
				end
				if (bitCnt_r == 5'd0) begin
					statusRead_r <= ~sdiSync_r[1];
				end
			end else if (selected & sckFall) begin
				statusSnap_r <= {statusSnap_r[14:0], 1'b0};
			end
			if (divCmd) begin
				clkDivBat_r <= cmdShift_r;
			end
		end
	end
	wire [2:0] divSel = clkDivBat_r[`RESL_DIV_SEL_HI:`RESL_DIV_SEL_LO];
	wire [3:0] batCode = clkDivBat_r[`RESL_BAT_HI:`RESL_BAT_LO];

	// -----------------------------------------------------------
	// transmit queue and holding registers
	// -----------------------------------------------------------
	wire qInReady;
	wire qOutValid;
	wire [7:0] qOutData;
	reg [7:0] txShift_r;
	reg [7:0] txHold_r;
	reg holdFull_r;
	reg [2:0] txBit_r;
	reg txHoldEmpty_r;
	reg txUnderrun_r;
	wire txActive = tx_register_enable & transmitter_on;
	resl_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH),
		.AW(3)
	) u_txq (
		.clk(clk),
		.rst(rst),
		.inValid(txWrCmd & tx_register_enable),
		.inReady(qInReady),
		.inData(cmdShift_r[7:0]),
		.outValid(qOutValid),
		.outReady(~holdFull_r),
		.outData(qOutData)
	);
	wire byteDone = txActive & txBitTick & (txBit_r == 3'd7);
	always @(posedge clk) begin
		if (rst | ~transmitter_on) begin
			txShift_r <= `RESL_TX_PREAMBLE;
			txHold_r <= `RESL_TX_PREAMBLE;
			holdFull_r <= 1'b1;
			txBit_r <= 3'd0;
		end else begin
			if (txActive & txBitTick) begin
				txBit_r <= txBit_r + 3'd1;
				txShift_r <= {txShift_r[6:0], 1'b0};
			end
			if (byteDone) begin
				txShift_r <= txHold_r;
			end
			if (byteDone & ~(qOutValid & ~holdFull_r)) begin
				holdFull_r <= 1'b0;
			end else if (qOutValid & ~holdFull_r) begin
				txHold_r <= qOutData;
				holdFull_r <= 1'b1;
			end
		end
	end
	always @(posedge clk) begin
		if (rst) begin
			txHoldEmpty_r <= 1'b0;
			txUnderrun_r <= 1'b0;
		end else begin
			txHoldEmpty_r <= txActive & ~holdFull_r;
			if (byteDone & ~holdFull_r & ~qOutValid) begin
				txUnderrun_r <= 1'b1;
			end else if (~tx_register_enable & ~transmitter_on) begin
				txUnderrun_r <= 1'b0;
			end
		end
	end

	// -----------------------------------------------------------
	// receive fifo level tracking
	// -----------------------------------------------------------
	reg [4:0] rxCount_r;
	reg [4:0] rxReadSince_r;
	reg rxFill_r;
	reg rxOverflow_r;
	reg statusOvfBit_r;
	wire rxOn = rx_queue_enable & rx_power_on;
	wire rxFull = (rxCount_r == `RESL_RX_FIFO_BITS);
	wire rxIn = rxOn & rxBitStrobe & ~rxFull;
	wire rxOut = rxOn & rxBitTaken & (rxCount_r != 5'd0);
	always @(posedge clk) begin
		if (rst | ~rxOn) begin
			rxCount_r <= 5'd0;
			rxReadSince_r <= 5'd0;
			rxFill_r <= 1'b0;
			rxOverflow_r <= 1'b0;
		end else begin
			if (rxIn & ~rxOut) begin
				rxCount_r <= rxCount_r + 5'd1;
			end else if (rxOut & ~rxIn) begin
				rxCount_r <= rxCount_r - 5'd1;
			end
			if (~rxFill_r) begin
				rxReadSince_r <= 5'd0;
				if (rxCount_r >= {1'b0, fifo_level_threshold}) begin
					rxFill_r <= 1'b1;
				end
			end else begin
				if (rxOut) begin
					rxReadSince_r <= rxReadSince_r + 5'd1;
				end
				if (rxOverflow_r | ~statusOvfBit_r) begin
					if (rxOverflow_r & rxOut & (rxCount_r == 5'd1)) begin
						rxFill_r <= 1'b0;
					end
				end
				if (~rxOverflow_r & rxOut
					& (rxReadSince_r + 5'd1 >= {1'b0, fifo_level_threshold})) begin
					rxFill_r <= 1'b0;
				end
			end
			if (rxBitStrobe & rxFull) begin
				rxOverflow_r <= 1'b1;
				rxFill_r <= 1'b1;
			end else if (rxOverflow_r & (rxCount_r == 5'd0)) begin
				rxOverflow_r <= 1'b0;
			end
		end
	end
	// overflow status bit clears on read, the fill request stays
	always @(posedge clk) begin
		if (rst | ~rxOn) begin
			statusOvfBit_r <= 1'b0;
		end else if (rxBitStrobe & rxFull) begin
			statusOvfBit_r <= 1'b1;
		end else if (readDone) begin
			statusOvfBit_r <= 1'b0;
		end
	end

	// -----------------------------------------------------------
	// latched and level events
	// -----------------------------------------------------------
	reg porEvent_r;
	reg wakeEvent_r;
	reg lowIrq_r;
	reg lowLevel_r;
	wire lowNow = battery_monitor_enable
		& (supplyDecivolts < `RESL_BAT_BASE_DV + {2'b00, batCode} * `RESL_BAT_STEP_DV);
	wire extEvent = extPinSelect & ~extSync_r[1];
	always @(posedge clk) begin
		if (rst) begin
			porEvent_r <= 1'b1;
			wakeEvent_r <= 1'b0;
			lowIrq_r <= 1'b0;
			lowLevel_r <= 1'b0;
			lowSupplyThresh_r <= `RESL_BAT_BASE_DV;
		end else begin
			lowLevel_r <= lowNow;
			lowSupplyThresh_r <= `RESL_BAT_BASE_DV + {2'b00, batCode};
			if (supplyReset | softResetCmd) begin
				porEvent_r <= 1'b1;
			end else if (readDone) begin
				porEvent_r <= 1'b0;
			end
			if (wake_timer_enable & wakeIntervalDone) begin
				wakeEvent_r <= 1'b1;
			end else if (readDone | ~wake_timer_enable) begin
				wakeEvent_r <= 1'b0;
			end
			if (lowNow & ~lowLevel_r) begin
				lowIrq_r <= 1'b1;
			end else if (readDone | ~battery_monitor_enable) begin
				lowIrq_r <= 1'b0;
			end
		end
	end

	// -----------------------------------------------------------
	// status word and request pin
	// -----------------------------------------------------------
	assign statusWord = {
		txHoldEmpty_r | rxFill_r,
		porEvent_r,
		txUnderrun_r | statusOvfBit_r,
		wakeEvent_r,
		extEvent,
		lowIrq_r | lowLevel_r,
		rxOn & (rxCount_r == 5'd0),
		antennaStrong,
		signalStrong,
		data_quality_flag,
		clockLocked,
		afcToggle,
		freq_offset_field
	};
	wire anyEvent = txHoldEmpty_r | rxFill_r | porEvent_r | txUnderrun_r
		| wakeEvent_r | extEvent | lowIrq_r;
	always @(posedge clk) begin
		if (rst) begin
			interrupt_request_n_r <= 1'b1;
			sdo_r <= 1'b0;
			txSerial_r <= 1'b0;
			txQueueReady_r <= 1'b0;
		end else begin
			interrupt_request_n_r <= ~anyEvent;
			txSerial_r <= txActive & txShift_r[7];
			txQueueReady_r <= qInReady & tx_register_enable;
			if (selected) begin
				sdo_r <= (statusRead_r | (bitCnt_r == 5'd0)) ? statusSnap_r[15] : 1'b0;
			end else begin
				sdo_r <= txActive & ~holdFull_r;
			end
		end
	end

	// -----------------------------------------------------------
	// oscillator control and mcu clock divider
	// -----------------------------------------------------------
	reg [5:0] divCnt_r;
	reg [5:0] divPeriod;
	always @* begin
		case (divSel)
			3'd0: divPeriod = `RESL_MCU_DIV_0;
			3'd1: divPeriod = `RESL_MCU_DIV_1;
			3'd2: divPeriod = `RESL_MCU_DIV_2;
			3'd3: divPeriod = `RESL_MCU_DIV_3;
			3'd4: divPeriod = `RESL_MCU_DIV_4;
			3'd5: divPeriod = `RESL_MCU_DIV_5;
			3'd6: divPeriod = `RESL_MCU_DIV_6;
			3'd7: divPeriod = `RESL_MCU_DIV_7;
			default: divPeriod = `RESL_MCU_DIV_0;
		endcase
	end
	wire oscOnlyEnable = clock_output_disable & ~rx_power_on & ~transmitter_on;
	always @(posedge clk) begin
		if (rst) begin
			oscRun_r <= 1'b1;
			divCnt_r <= 6'd0;
			mcuClkOut_r <= 1'b0;
		end else begin
			if (oscOnlyEnable) begin
				oscRun_r <= osc_enable;
			end else begin
				oscRun_r <= osc_enable | anyEvent;
			end
			if (~oscRun_r | clock_output_disable | (divCnt_r >= divPeriod - 6'd1)) begin
				divCnt_r <= 6'd0;
			end else begin
				divCnt_r <= divCnt_r + 6'd1;
			end
			mcuClkOut_r <= oscRun_r & ~clock_output_disable
				& (divCnt_r < {1'b0, divPeriod[5:1]});
		end
	end
endmodule // resl_event_status

// >>> sim/resl_event_status_assertions.sv
// port checker for the event and status logic
`timescale 1ns/1ps
module resl_event_status_chk #(
	parameter FIFO_DEPTH = 8
) (
	input wire clk,
	input wire rst,
	input wire interrupt_request_n_r,
	input wire mcuClkOut_r,
	input wire oscRun_r,
	input wire txQueueReady_r,
	input wire [5:0] lowSupplyThresh_r,
	input wire tx_register_enable,
	input wire transmitter_on,
	input wire rx_power_on,
	input wire osc_enable,
	input wire clock_output_disable,
	input wire extPinSelect,
	input wire outside_event_pin_n
);
	reg mcuPrev_r;
	reg [7:0] mcuHold_r;
	// ---------------------------------------------
	// cycles since the mcu clock last changed
	// ---------------------------------------------
	always @(posedge clk) begin
		mcuPrev_r <= mcuClkOut_r;
		if (rst || !oscRun_r || clock_output_disable || mcuClkOut_r != mcuPrev_r) begin
			mcuHold_r <= 8'h00;
		end else begin
			mcuHold_r <= mcuHold_r + 8'h01;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	chk_por_request: assert property ($fell(rst) |-> ##[0:2] !interrupt_request_n_r)
		else $error("request not raised after reset");
	chk_thresh_reset: assert property ($fell(rst) |-> lowSupplyThresh_r == 6'h16)
		else $error("threshold not at power-on value");
	chk_thresh_range: assert property (lowSupplyThresh_r >= 6'h16 && lowSupplyThresh_r <= 6'h25)
		else $error("threshold outside code range");
	chk_osc_event: assert property (!interrupt_request_n_r && !clock_output_disable |-> ##[0:2] oscRun_r)
		else $error("oscillator stopped with event active");
	chk_osc_only_enable: assert property ((clock_output_disable && !rx_power_on && !transmitter_on && !osc_enable) [*3] |-> !oscRun_r)
		else $error("oscillator ignores its enable");
	chk_ext_follow: assert property ((extPinSelect && !outside_event_pin_n) [*6] |-> !interrupt_request_n_r)
		else $error("external pin low without request");
	chk_txq_disabled: assert property ((!tx_register_enable) [*2] |-> !txQueueReady_r)
		else $error("queue ready while register mode off");
	chk_mcu_period: assert property (mcuHold_r < 8'h1A)
		else $error("mcu clock half period too long");
endmodule // resl_event_status_chk

bind resl_event_status resl_event_status_chk #(.FIFO_DEPTH(FIFO_DEPTH)) i_chk (
	.clk(clk),
	.rst(rst),
	.interrupt_request_n_r(interrupt_request_n_r),
	.mcuClkOut_r(mcuClkOut_r),
	.oscRun_r(oscRun_r),
	.txQueueReady_r(txQueueReady_r),
	.lowSupplyThresh_r(lowSupplyThresh_r),
	.tx_register_enable(tx_register_enable),
	.transmitter_on(transmitter_on),
	.rx_power_on(rx_power_on),
	.osc_enable(osc_enable),
	.clock_output_disable(clock_output_disable),
	.extPinSelect(extPinSelect),
	.outside_event_pin_n(outside_event_pin_n)
);

// >>> sim/resl_mcu_model.sv
// serial master model of the host microcontroller
`timescale 1ns/1ps
module resl_mcu_model (
	input wire logic clk,
	output logic spiSck,
	output logic spiSdi,
	output logic spiSel_n,
	input wire logic sdo_r
);
	initial begin
		spiSck = 1'b0;
		spiSdi = 1'b0;
		spiSel_n = 1'b1;
	end
	// ---------------------------------------------
	// one 16-bit frame, sck idles low between frames
	// ---------------------------------------------
	task automatic xfer(input logic [15:0] cmd, output logic [15:0] rd);
		int i;
		@(negedge clk);
		spiSel_n = 1'b0;
		repeat (6) @(negedge clk);
		for (i = 15; i >= 0; i--) begin
			spiSdi = cmd[i];
			repeat (6) @(negedge clk);
			spiSck = 1'b1;
			rd[i] = sdo_r;
			repeat (6) @(negedge clk);
			spiSck = 1'b0;
		end
		repeat (2) @(negedge clk);
		spiSel_n = 1'b1;
		spiSdi = ~spiSdi;
		repeat (8) @(negedge clk);
	endtask
endmodule // resl_mcu_model

// >>> sim/resl_event_status_tb_top.sv
// testbench for the event and status logic
`timescale 1ns/1ps
module resl_event_status_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic tx_register_enable = 1'b0, transmitter_on = 1'b0, rx_power_on = 1'b0;
	logic rx_queue_enable = 1'b0, wake_timer_enable = 1'b0, battery_monitor_enable = 1'b0;
	logic osc_enable = 1'b1, clock_output_disable = 1'b0, extPinSelect = 1'b0;
	logic [3:0] fifo_level_threshold = 4'h4, freq_offset_field = 4'hB;
	logic txBitTick = 1'b0, rxBitStrobe = 1'b0, rxBitTaken = 1'b0, wakeIntervalDone = 1'b0;
	logic softResetCmd = 1'b0, supplyReset = 1'b0, outside_event_pin_n = 1'b1;
	logic [5:0] supplyDecivolts = 6'h1E;
	logic antennaStrong = 1'b1, signalStrong = 1'b0, data_quality_flag = 1'b1;
	logic clockLocked = 1'b0, afcToggle = 1'b1;
	wire spiSck, spiSdi, spiSel_n, sdo_r, interrupt_request_n_r, mcuClkOut_r, oscRun_r;
	wire txSerial_r, txQueueReady_r;
	wire [5:0] lowSupplyThresh_r;
	int err_count = 0;
	int checks = 0;
	int n;
	logic [15:0] st;
	resl_event_status #(.FIFO_DEPTH(8)) i_dut (
		.clk(clk), .rst(rst), .spiSck(spiSck), .spiSdi(spiSdi), .spiSel_n(spiSel_n),
		.sdo_r(sdo_r), .interrupt_request_n_r(interrupt_request_n_r),
		.mcuClkOut_r(mcuClkOut_r), .oscRun_r(oscRun_r), .txSerial_r(txSerial_r),
		.txQueueReady_r(txQueueReady_r), .lowSupplyThresh_r(lowSupplyThresh_r),
		.tx_register_enable(tx_register_enable), .transmitter_on(transmitter_on),
		.rx_power_on(rx_power_on), .rx_queue_enable(rx_queue_enable),
		.wake_timer_enable(wake_timer_enable), .battery_monitor_enable(battery_monitor_enable),
		.osc_enable(osc_enable), .clock_output_disable(clock_output_disable),
		.extPinSelect(extPinSelect), .fifo_level_threshold(fifo_level_threshold),
		.txBitTick(txBitTick), .rxBitStrobe(rxBitStrobe), .rxBitTaken(rxBitTaken),
		.wakeIntervalDone(wakeIntervalDone), .softResetCmd(softResetCmd),
		.supplyReset(supplyReset), .supplyDecivolts(supplyDecivolts),
		.outside_event_pin_n(outside_event_pin_n), .antennaStrong(antennaStrong),
		.signalStrong(signalStrong), .data_quality_flag(data_quality_flag),
		.clockLocked(clockLocked), .afcToggle(afcToggle), .freq_offset_field(freq_offset_field)
	);
	resl_mcu_model i_mcu (.clk(clk), .spiSck(spiSck), .spiSdi(spiSdi), .spiSel_n(spiSel_n),
		.sdo_r(sdo_r));
	initial begin
		forever #10 clk = ~clk;
	end
	// ---------------------------------------------
	// shared tasks
	// ---------------------------------------------
	task automatic close_out();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic waitIrq(input logic lvl);
		int k;
		for (k = 0; k < 400 && interrupt_request_n_r !== lvl; k++) @(negedge clk);
		chk("request", {15'h0000, lvl}, {15'h0000, interrupt_request_n_r});
		if (interrupt_request_n_r !== lvl) close_out();
	endtask
	task automatic pulseN(input int sel, input int cnt);
		repeat (cnt) begin
			@(negedge clk);
			case (sel)
				0: txBitTick = 1'b1;
				1: rxBitStrobe = 1'b1;
				2: rxBitTaken = 1'b1;
				4: supplyReset = 1'b1;
				5: softResetCmd = 1'b1;
				default: wakeIntervalDone = 1'b1;
			endcase
			@(negedge clk);
			{txBitTick, rxBitStrobe, rxBitTaken, wakeIntervalDone, supplyReset, softResetCmd} = 6'h00;
			repeat (2) @(negedge clk);
		end
	endtask
	task automatic period(output int p);
		int k;
		for (k = 0; k < 300 && mcuClkOut_r !== 1'b1; k++) @(negedge clk);
		for (k = 0; k < 300 && mcuClkOut_r !== 1'b0; k++) @(negedge clk);
		for (p = 0; p < 300 && mcuClkOut_r !== 1'b1; p++) @(negedge clk);
		for (p = p; p < 300 && mcuClkOut_r !== 1'b0; p++) @(negedge clk);
		if (p >= 300) begin
			chk("mcu clock timeout", 16'h0000, 16'h0001);
			close_out();
		end
	endtask
	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		repeat (8) @(negedge clk);
		rst = 1'b0;
		waitIrq(1'b0);
		chk("threshold", 16'h0016, {10'h000, lowSupplyThresh_r});
		i_mcu.xfer(16'h0000, st);
		chk("power-up bit", 16'h4000, st & 16'h4000);
		waitIrq(1'b1);
		i_mcu.xfer(16'h0000, st);
		chk("status word", 16'h015B, st);
		period(n);
		chk("mcu period", 16'h0032, n[15:0]);
		i_mcu.xfer(16'hC0E3, st);
		chk("threshold", 16'h0019, {10'h000, lowSupplyThresh_r});
		period(n);
		period(n);
		chk("mcu period", 16'h0005, n[15:0]);
		i_mcu.xfer(16'hC0F5, st);
		chk("threshold", 16'h0019, {10'h000, lowSupplyThresh_r});
		battery_monitor_enable = 1'b1;
		supplyDecivolts = 6'h18;
		waitIrq(1'b0);
		i_mcu.xfer(16'h0000, st);
		chk("low supply", 16'h0400, st & 16'h0400);
		waitIrq(1'b1);
		i_mcu.xfer(16'h0000, st);
		chk("low supply held", 16'h0400, st & 16'h0400);
		supplyDecivolts = 6'h1E;
		i_mcu.xfer(16'h0000, st);
		chk("low supply gone", 16'h0000, st & 16'h0400);
		pulseN(3, 1);
		repeat (10) @(negedge clk);
		chk("wake disabled", 16'h0001, {15'h0000, interrupt_request_n_r});
		wake_timer_enable = 1'b1;
		pulseN(3, 1);
		waitIrq(1'b0);
		i_mcu.xfer(16'h0000, st);
		chk("wake", 16'h1000, st & 16'h1000);
		waitIrq(1'b1);
		for (n = 4; n < 6; n++) begin
			pulseN(n, 1);
			waitIrq(1'b0);
			i_mcu.xfer(16'h0000, st);
			chk("reset event", 16'h4000, st & 16'h4000);
			waitIrq(1'b1);
		end
		extPinSelect = 1'b1;
		outside_event_pin_n = 1'b0;
		waitIrq(1'b0);
		clock_output_disable = 1'b1;
		osc_enable = 1'b0;
		repeat (6) @(negedge clk);
		chk("oscillator", 16'h0000, {15'h0000, oscRun_r});
		clock_output_disable = 1'b0;
		repeat (6) @(negedge clk);
		chk("oscillator", 16'h0001, {15'h0000, oscRun_r});
		i_mcu.xfer(16'h0000, st);
		chk("external", 16'h0800, st & 16'h0800);
		outside_event_pin_n = 1'b1;
		osc_enable = 1'b1;
		waitIrq(1'b1);
		rx_power_on = 1'b1;
		rx_queue_enable = 1'b1;
		i_mcu.xfer(16'h0000, st);
		chk("fifo empty", 16'h0200, st & 16'h8200);
		pulseN(1, 4);
		waitIrq(1'b0);
		i_mcu.xfer(16'h0000, st);
		chk("fill", 16'h8000, st & 16'h8200);
		pulseN(2, 4);
		waitIrq(1'b1);
		pulseN(1, 17);
		i_mcu.xfer(16'h0000, st);
		chk("overflow", 16'hA000, st & 16'hA000);
		i_mcu.xfer(16'h0000, st);
		chk("overflow cleared", 16'h8000, st & 16'hA000);
		chk("request held", 16'h0000, {15'h0000, interrupt_request_n_r});
		rx_power_on = 1'b0;
		waitIrq(1'b1);
		rx_queue_enable = 1'b0;
		tx_register_enable = 1'b1;
		repeat (10) i_mcu.xfer(16'hB855, st);
		chk("queue full", 16'h0000, {15'h0000, txQueueReady_r});
		transmitter_on = 1'b1;
		repeat (3) @(negedge clk);
		chk("tx serial", 16'h0001, {15'h0000, txSerial_r});
		pulseN(0, 1);
		chk("tx serial", 16'h0000, {15'h0000, txSerial_r});
		pulseN(0, 95);
		chk("queue drained", 16'h0001, {15'h0000, txQueueReady_r});
		waitIrq(1'b0);
		chk("sdo ready", 16'h0001, {15'h0000, sdo_r});
		i_mcu.xfer(16'h0000, st);
		chk("underrun", 16'hA000, st & 16'hA000);
		tx_register_enable = 1'b0;
		transmitter_on = 1'b0;
		waitIrq(1'b1);
		close_out();
	end
endmodule // resl_event_status_tb_top
